// File: hdl/srs_readback.v
// Serial readback path: frame formatting, streaming and frame-length check
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.vh"

module srs_readback (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    // Serial link pins
    input  wire        sclk,
    input  wire        sync_n,
    input  wire        sdi,
    output wire        sdo,
    // Readback select settings
    input  wire        return_status_select,
    input  wire        auto_read_en,
    input  wire [6:0]  read_sel_addr,
    // Status sources for the status header
    input  wire        alert_in,
    input  wire        adc_data_rdy,
    input  wire [3:0]  din_comp,
    // Register file read port
    output wire [6:0]  reg_rd_addr,
    input  wire [15:0] reg_rd_data,
    // Received write frame
    output wire        frame_valid,
    output wire [31:0] frame_word,
    // Frame-length error flag
    input  wire        err_clear,
    input  wire        err_mask,
    output wire        frame_length_error,
    output wire        alert
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // CRC-8 over a 24-bit payload, MSB first
    function [7:0] crc24;
        input [23:0] d;
        integer i;
        reg [7:0] c;
        reg       fb;
        begin
            c = `SRS_CRC_INIT;
            for (i = 23; i >= 0; i = i - 1) begin
                fb = c[7] ^ d[i];
                c  = {c[6:0], 1'b0} ^ (fb ? `SRS_CRC_POLY : 8'h00);
            end
            crc24 = c;
        end
    endfunction

    // Full return word for a given address and contents
    function [31:0] fmt_word;
        input [6:0]  a;
        input [15:0] d;
        input        st;
        input [5:0]  s;
        reg   [23:0] p;
        begin
            p = st ? {1'b1, 1'b0, s, d} : {1'b1, a, d};
            fmt_word = {p, crc24(p)};
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [2:0] sclk_q;
    reg [2:0] sync_q;
    reg [1:0] sdi_q;

    // Two flops before use; third stage only for edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h7;  // Parked-high idle, so reset makes no false edge
            sync_q <= 3'h7;
            sdi_q  <= 2'h0;
        end else if (ce) begin
            sclk_q <= {sclk_q[1:0], sclk};
            sync_q <= {sync_q[1:0], sync_n};
            sdi_q  <= {sdi_q[0], sdi};
        end
    end

    wire sclk_rise = sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = ~sclk_q[1] & sclk_q[2];
    wire sync_fall = ~sync_q[1] & sync_q[2];
    wire sync_rise = sync_q[1] & ~sync_q[2];
    wire in_frame  = ~sync_q[1];

    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    reg [31:0] tx_q;
    reg [31:0] rx_q;
    reg [5:0]  bitcnt_q;
    reg        strm_q;
    reg        extra_q;
    reg        ovf_q;
    reg        armed_q;
    reg        ret_en_q;
    reg [6:0]  addr_q;
    reg        fvalid_q;
    reg [31:0] fword_q;
    reg        err_q;

    wire [5:0] status_bits = {alert_in, adc_data_rdy, din_comp};
    wire [31:0] next_word  = fmt_word(addr_q, ret_en_q ? reg_rd_data : 16'h0000,
                                      return_status_select, status_bits);
    // Return enabled by auto-read or by a preceding select write
    wire ret_en = auto_read_en | armed_q;
    wire word_done = strm_q ? (bitcnt_q == `SRS_STREAM_BITS - 6'd1)
                            : (bitcnt_q == `SRS_FRAME_BITS - 6'd1);
    wire len_ok  = strm_q & (bitcnt_q == 6'd0) & ~ovf_q;
    wire wr_ok   = len_ok & ~extra_q & (crc24(rx_q[31:8]) == rx_q[7:0]);

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    // The next register is fetched during the current word, so its data
    // is stable long before the word boundary on a slow serial clock.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q     <= `SRS_WORD_RESET;
            addr_q   <= `SRS_ADDR_RESET;
            ret_en_q <= 1'b0;
        end else if (ce) begin
            if (!in_frame) begin
                addr_q   <= read_sel_addr;
                ret_en_q <= ret_en;
            end else if (sync_fall) begin
                tx_q   <= next_word;
                addr_q <= addr_q + 7'd1;
            end else if (sclk_fall && word_done && ret_en_q) begin
                // Park next word below the current bit; the rise shifts it up
                tx_q   <= {tx_q[31], next_word[23:0], 7'h00};
                addr_q <= addr_q + 7'd1;
            end else if (sclk_rise) begin
                tx_q <= {tx_q[30:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive side and clock counting
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q     <= `SRS_WORD_RESET;
            bitcnt_q <= 6'd0;
            strm_q   <= 1'b0;
            extra_q  <= 1'b0;
            ovf_q    <= 1'b0;
            armed_q  <= 1'b0;
        end else if (ce) begin
            if (sync_fall) begin
                bitcnt_q <= 6'd0;
                strm_q   <= 1'b0;
                extra_q  <= 1'b0;
                ovf_q    <= 1'b0;
            end else if (sync_rise) begin
                // Arm only after a clean write to the select register
                armed_q <= wr_ok && (rx_q[`SRS_ADDR_MSB:`SRS_ADDR_LSB] == `SRS_READ_SELECT_ADDR);
            end else if (in_frame && sclk_fall) begin
                if (!strm_q) begin
                    rx_q <= {rx_q[30:0], sdi_q[1]};
                    if (word_done) begin
                        strm_q   <= 1'b1;
                        bitcnt_q <= 6'd0;
                    end else begin
                        bitcnt_q <= bitcnt_q + 6'd1;
                    end
                end else begin
                    // Input bits are dropped once the first word is done
                    if (!ret_en_q)
                        ovf_q <= 1'b1;
                    extra_q  <= 1'b1;
                    bitcnt_q <= word_done ? 6'd0 : bitcnt_q + 6'd1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Frame hand-off and error flag
    // ----------------------------------------------------------------
    // Set beats clear so an ending frame is never lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fvalid_q <= 1'b0;
            fword_q  <= `SRS_WORD_RESET;
            err_q    <= 1'b0;
        end else if (ce) begin
            fvalid_q <= sync_rise & wr_ok;
            if (sync_rise && wr_ok)
                fword_q <= rx_q;
            if (sync_rise && !len_ok)
                err_q <= 1'b1;
            else if (err_clear)
                err_q <= 1'b0;
        end
    end

    assign sdo                = tx_q[31];
    assign reg_rd_addr        = addr_q;
    assign frame_valid        = fvalid_q;
    assign frame_word         = fword_q;
    assign frame_length_error = err_q;
    assign alert              = err_q & ~err_mask;

endmodule
`default_nettype wire

// File: include/srs_map.vh
// Constants for the serial readback streaming block
//
// Contract
// - Status select low: bit 31 one, address echo, data, CRC.
// - Status select high: 1, 0, alert, result ready, comparator levels, data, CRC.
// - Streaming advances to next register address after each returned word.
// - Each streamed word carries 16-bit contents and 8-bit CRC, with no address.
// - Frame-length error when clock count differs from 32 plus 24 per word.
// - Data received while streaming never reaches the register map.
// - Auto-read enabled: every transaction returns the selected register.
// - Auto-read drives the selected pointer's contents during each transfer.
// - Auto-read: after frame select rises, selected address returns again.
// - Auto-read: frame select held low streams consecutive addresses.
// - CRC-8 polynomial x^8+x^2+x+1 over the preceding 24 bits.
// - Leading bit on frame select fall, others on clock rising edges.
// - Incoming data sampled on clock falling edges, MSB first, 32 bits.
`ifndef SRS_MAP_VH
`define SRS_MAP_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SRS_FRAME_BITS      6'd32
`define SRS_STREAM_BITS     6'd24
`define SRS_ADDR_MSB        30
`define SRS_ADDR_LSB        24
`define SRS_DATA_MSB        23
`define SRS_DATA_LSB        8
`define SRS_CRC_POLY        8'h07
`define SRS_CRC_INIT        8'h00

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define SRS_READ_SELECT_ADDR 7'h41
`define SRS_ADDR_RESET      7'h00
`define SRS_WORD_RESET      32'h0000_0000

`endif

// File: testbench/srs_readback_checker.sv
// Assertion checker for the serial readback block
`timescale 1ns/1ps
`default_nettype none
module srs_readback_checker (
    // Clock and link
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclk,
    input wire logic       sync_n,
    input wire logic       sdo,
    // Read port and flags
    input wire logic [6:0] read_sel_addr,
    input wire logic [6:0] reg_rd_addr,
    input wire logic       frame_valid,
    input wire logic       err_clear,
    input wire logic       err_mask,
    input wire logic       frame_length_error,
    input wire logic       alert
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // Properties
    // ----------------
    property p_alert; alert == (frame_length_error & ~err_mask); endproperty
    a_alert: assert property (p_alert) else $error("alert mismatch");
    property p_sticky; frame_length_error && !err_clear |=> frame_length_error; endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_pulse; frame_valid |=> !frame_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_lead; $fell(sync_n) |-> ##[1:5] sdo; endproperty
    a_lead: assert property (p_lead) else $error("no leading one");
    // Low phase is four cycles; sdo moves only after a rise
    property p_hold; (!sclk && !sync_n)[*4] |-> $stable(sdo); endproperty
    a_hold: assert property (p_hold) else $error("sdo moved");
    property p_idle; sync_n[*8] |-> reg_rd_addr == $past(read_sel_addr); endproperty
    a_idle: assert property (p_idle) else $error("bad idle addr");
    property p_step; !sync_n && $changed(reg_rd_addr) |-> reg_rd_addr == $past(reg_rd_addr) + 7'h1; endproperty
    a_step: assert property (p_step) else $error("bad addr step");
    property p_end; $rose(frame_length_error) || frame_valid |-> sync_n; endproperty
    a_end: assert property (p_end) else $error("early frame end");
    c_valid: cover property (frame_valid);
    c_err: cover property ($rose(frame_length_error));
    c_step: cover property (!sync_n && $changed(reg_rd_addr));
endmodule
bind srs_readback srs_readback_checker u_chk (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n),
    .sdo(sdo), .read_sel_addr(read_sel_addr), .reg_rd_addr(reg_rd_addr), .frame_valid(frame_valid),
    .err_clear(err_clear), .err_mask(err_mask), .frame_length_error(frame_length_error), .alert(alert));
`default_nettype wire

// File: testbench/srs_spi_master.sv
// Behavioural serial master driving frames and capturing returned bits
`timescale 1ns/1ps
`default_nettype none
module srs_spi_master (
    // Link pins
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi,
    input  wire logic sdo
);
    logic [127:0] rxv;  // Returned bits, newest in bit 0
    // ----------------
    // Frame check
    // ----------------
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // Clock parks high so the first edge in a frame is a fall
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdi = 1'b0;
        rxv = '0;
    end
    // Frame of n falls; filler toggles so stale data never looks valid
    task automatic frame(input logic [31:0] w, input int n);
        #13 sync_n = 1'b0;
        sdi = w[31];
        #300;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            #200 rxv = {rxv[126:0], sdo};
            sclk = 1'b1;
            sdi = (i < 31) ? w[30-i] : ~sdi;
            #200;
        end
        sync_n = 1'b1;
        sdi = ~sdi;
        #1000;
    endtask
endmodule
`default_nettype wire

// File: testbench/test_srs_readback.sv
// Self-checking bench for the serial readback block
`timescale 1ns/1ps
`default_nettype none
module test_srs_readback;
    logic        clk, rst_n, rss, ar, alert_in, rdy, err_clear, err_mask;
    logic [3:0]  din;
    logic [6:0]  sel;
    wire  [6:0]  rd_addr;
    wire  [31:0] fw;
    wire         sclk, sync_n, sdi, sdo, fv, fle, alert;
    int          fail_count, total_checks, fv_cnt, fv_base;
    // Register file holds a fixed pattern of its address
    function automatic logic [15:0] regval(input logic [6:0] a);
        return {a, ~a, a[1:0]};
    endfunction
    function automatic logic [31:0] expw(input logic [6:0] a);
        logic [23:0] h;
        h = {1'b1, rss ? {1'b0, alert_in, rdy, din} : a, regval(a)};
        return {h, u_m.crc8(h)};
    endfunction
    srs_readback uut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
        .return_status_select(rss), .auto_read_en(ar), .read_sel_addr(sel), .alert_in(alert_in),
        .adc_data_rdy(rdy), .din_comp(din), .reg_rd_addr(rd_addr), .reg_rd_data(regval(rd_addr)),
        .frame_valid(fv), .frame_word(fw), .err_clear(err_clear), .err_mask(err_mask),
        .frame_length_error(fle), .alert(alert));
    srs_spi_master u_m (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fv === 1'b1) fv_cnt++;
    end
    // Hang guard
    initial begin
        #4000000;
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_n, rss, ar, alert_in, rdy, err_clear, err_mask, din, sel} = '0;
        void'($urandom(54510));
        repeat (5) @(negedge clk);
        check({fv, fle, alert, sdo}, 4'h0);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        for (int it = 0; it < 8; it++) begin
            int k, bad, n;
            @(negedge clk);
            k = it % 4;
            bad = (it == 5) ? 1 + $urandom_range(22) : 0;
            ar = it[0];
            {alert_in, rdy, din, rss, err_mask, sel} = 15'($urandom);
            // Let the read pointer settle before the frame opens
            repeat (4) @(negedge clk);
            fv_base = fv_cnt;
            if (!ar) begin
                u_m.frame({8'h41, 16'h0000, u_m.crc8(24'h410000)}, 32);
                check(fv_cnt - fv_base, 1);
                check(fw, {8'h41, 16'h0000, u_m.crc8(24'h410000)});
            end
            fv_base = fv_cnt;
            n = 32 + 24 * k + bad;
            u_m.frame(32'h0, n);
            check(u_m.rxv[n-1 -: 32], expw(sel));
            for (int m = 1; m <= k; m++) check(u_m.rxv[n-9-24*m -: 24], expw(7'(sel + m)) & 32'hff_ffff);
            check(fv_cnt - fv_base, (k == 0 && bad == 0) ? 1 : 0);
            check(fle, bad != 0);
            check(alert, (bad != 0) & ~err_mask);
            @(negedge clk);
            err_clear = 1'b1;
            @(negedge clk);
            err_clear = 1'b0;
            @(negedge clk);
            check(fle, 1'b0);
        end
        // Corner: long frame with readback off counts as a length error
        @(negedge clk);
        ar = 1'b0;
        repeat (4) @(negedge clk);
        fv_base = fv_cnt;
        u_m.frame(32'h0, 56);
        check(fle, 1'b1);
        check(fv_cnt - fv_base, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
